/* common/nvram_i2c_pkg.sv */
// Shared constants for the two-wire nonvolatile memory slave and its bus master.
package nvram_i2c_pkg;
	// ==========================================================
	// Slave addressing and reserved identifiers.
	localparam logic [3:0] TYPE_CODE = 4'ha;
	localparam logic [7:0] RES_ID_PREFIX = 8'hf8;
	localparam logic [7:0] RES_ID_SLEEP = 8'h86;
	localparam logic [7:0] RES_ID_IDENT = 8'hf9;
	// ==========================================================
	// Memory array.
	localparam int ADDR_BITS = 14;
	localparam int MEM_DEPTH = 16384;
	localparam int ADDR_HI_USED = 6;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] ACKED_SLOT = 4'h9;
	// ==========================================================
	// Identity word layout.
	localparam int ID_BYTES = 3;
	localparam int ID_RSVD_BIT_A = 0;
	localparam int ID_RSVD_BIT_B = 4;
	localparam logic ID_RSVD_VAL = 1'b0;
	// ==========================================================
	// Timing.
	localparam int CORE_CLK_MHZ = 250;
	localparam int WAKE_RECOVERY_US = 400;
	localparam int WAKE_RECOVERY_CYCLES = WAKE_RECOVERY_US * CORE_CLK_MHZ;
	localparam int SCL_QUARTER_CYCLES = 63;
	// ==========================================================
	// Master register map and fields.
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [1:0] OP_START = 2'h0;
	localparam logic [1:0] OP_STOP = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam int CMD_ACK_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NACK_BIT = 1;
endpackage : nvram_i2c_pkg

/* common/i2c_link_if.sv */
// Two-wire link carrier with open-drain resolution of both lines.
`timescale 1ns/1ps
interface i2c_link_if;
	logic mSclOut;
	logic mSclOe_n;
	logic mSdaOut;
	logic mSdaOe_n;
	logic dSdaOut;
	logic dSdaOe_n;
	logic sclLevel;
	logic sdaLevel;
	// A line is low when any enabled driver pulls it low, else pulled high.
	assign sclLevel = !(!mSclOe_n && !mSclOut);
	assign sdaLevel = !((!mSdaOe_n && !mSdaOut) || (!dSdaOe_n && !dSdaOut));
	modport device (input sclLevel, input sdaLevel, output dSdaOut, output dSdaOe_n);
	modport master (input sclLevel, input sdaLevel, output mSclOut, output mSclOe_n,
		output mSdaOut, output mSdaOe_n);
endinterface : i2c_link_if

/* src/nvram_i2c_device.sv */
// Two-wire slave end of the nonvolatile memory with sleep and identity read.
`timescale 1ns/1ps
module nvram_i2c_device import nvram_i2c_pkg::*; #(
	parameter int WAKE_CYCLES = WAKE_RECOVERY_CYCLES,
	parameter logic [11:0] MFR_ID = 12'h5a3, // Arbitrary value.
	parameter logic [3:0] DENSITY_ID = 4'h6, // Arbitrary value.
	parameter logic [4:0] VARIATION_ID = 5'h0a, // Arbitrary value.
	parameter logic [2:0] DIE_REV = 3'h5 // Arbitrary value.
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Two-wire link.
	i2c_link_if.device link,
	// Select and protect pins.
	input wire logic [2:0] addrSel,
	input wire logic writeProtect,
	// Status.
	output logic asleep
);
	// ==========================================================
	// Types and state.
	localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} dev_state_type;
	typedef enum logic [2:0] {K_SLAVE, K_IDSEL, K_ADDR_HI, K_ADDR_LO, K_DATA} byte_kind_type;
	typedef struct packed {
		logic [2:0] sclSync;
		logic [2:0] sdaSync;
		logic [2:0] wpSync;
		logic scl;
		logic sda;
		logic wp;
		dev_state_type state;
		byte_kind_type kind;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] addrHi;
		logic [ADDR_BITS-1:0] addr;
		logic readMode;
		logic idMode;
		logic [1:0] idIdx;
		logic resArmed;
		logic sleepPend;
		logic asleep;
		logic waking;
		logic [WAKE_W-1:0] wakeCnt;
		logic sdaOe_n;
	} dev_reg_type;
	dev_reg_type r;
	dev_reg_type n;
	logic [7:0] mem [MEM_DEPTH];
	logic memWe;
	logic sclNew;
	logic sdaNew;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic ownAddr;
	logic ack;
	logic [8:0] partField;
	logic [23:0] idWord;
	logic [7:0] txByte;

	// ==========================================================
	// Identity word with the reserved part bits pinned.
	always_comb begin
		partField = {DENSITY_ID, VARIATION_ID};
		partField[ID_RSVD_BIT_A] = ID_RSVD_VAL;
		partField[ID_RSVD_BIT_B] = ID_RSVD_VAL;
		idWord = {MFR_ID, partField, DIE_REV};
		unique case (r.idIdx)
			2'h0: txByte = idWord[23:16];
			2'h1: txByte = idWord[15:8];
			default: txByte = idWord[7:0];
		endcase
		if (!r.idMode) begin
			txByte = mem[r.addr];
		end
	end

	// ==========================================================
	// Line filtering and bus condition detection.
	always_comb begin
		sclNew = (r.sclSync[1] == r.sclSync[2]) ? r.sclSync[1] : r.scl;
		sdaNew = (r.sdaSync[1] == r.sdaSync[2]) ? r.sdaSync[1] : r.sda;
		sclRise = !r.scl && sclNew;
		sclFall = r.scl && !sclNew;
		startCond = r.scl && sclNew && r.sda && !sdaNew;
		stopCond = r.scl && sclNew && !r.sda && sdaNew;
		ownAddr = (r.shift[7:1] == {TYPE_CODE, addrSel});
	end

	// ==========================================================
	// Protocol engine.
	always_comb begin
		n = r;
		memWe = 1'b0;
		ack = 1'b0;
		n.sclSync = {r.sclSync[1:0], link.sclLevel};
		n.sdaSync = {r.sdaSync[1:0], link.sdaLevel};
		n.wpSync = {r.wpSync[1:0], writeProtect};
		n.scl = sclNew;
		n.sda = sdaNew;
		if (r.wpSync[1] == r.wpSync[2]) begin
			n.wp = r.wpSync[1];
		end
		// Recovery timer: commands are refused until it expires.
		if (r.waking) begin
			n.wakeCnt = r.wakeCnt + WAKE_W'(1);
			if (r.wakeCnt == WAKE_W'(WAKE_CYCLES - 1)) begin
				n.waking = 1'b0;
			end
		end
		if (startCond) begin
			// A start aborts any byte in flight; the address latch is kept.
			n.state = ST_RX;
			n.kind = K_SLAVE;
			n.bitCnt = 4'h0;
			n.sdaOe_n = 1'b1;
			n.readMode = 1'b0;
			n.idMode = 1'b0;
		end else if (stopCond) begin
			n.state = ST_IDLE;
			n.sdaOe_n = 1'b1;
			n.resArmed = 1'b0;
			n.idMode = 1'b0;
			if (r.sleepPend) begin
				n.asleep = 1'b1;
				n.sleepPend = 1'b0;
			end
		end else begin
			unique case (r.state)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (sclRise && r.bitCnt < ACK_SLOT) begin
						n.shift = {r.shift[6:0], sdaNew};
						n.bitCnt = r.bitCnt + 4'h1;
					end else if (sclFall && r.bitCnt == ACK_SLOT) begin
						unique case (r.kind)
							K_SLAVE: begin
								n.resArmed = 1'b0;
								if (r.asleep || r.waking) begin
									// Own address starts the wake; nack meanwhile.
									if (ownAddr && r.asleep) begin
										n.asleep = 1'b0;
										n.waking = 1'b1;
										n.wakeCnt = '0;
									end
								end else if (r.resArmed && r.shift == RES_ID_SLEEP) begin
									ack = 1'b1;
									n.sleepPend = 1'b1;
								end else if (r.resArmed && r.shift == RES_ID_IDENT) begin
									ack = 1'b1;
									n.readMode = 1'b1;
									n.idMode = 1'b1;
									n.idIdx = 2'h0;
								end else if (r.shift == RES_ID_PREFIX) begin
									ack = 1'b1;
									n.kind = K_IDSEL;
								end else if (ownAddr) begin
									ack = 1'b1;
									n.readMode = r.shift[0];
									n.kind = K_ADDR_HI;
								end
							end
							K_IDSEL: begin
								// Direction bit is ignored here.
								ack = ownAddr;
								n.resArmed = ownAddr;
							end
							K_ADDR_HI: begin
								ack = 1'b1;
								n.addrHi = r.shift;
								n.kind = K_ADDR_LO;
							end
							K_ADDR_LO: begin
								ack = 1'b1;
								n.addr = {r.addrHi[ADDR_HI_USED-1:0], r.shift};
								n.kind = K_DATA;
							end
							K_DATA: begin
								// Protected bytes get no ack and leave the counter alone.
								if (!r.wp) begin
									memWe = 1'b1;
									ack = 1'b1;
									n.addr = r.addr + ADDR_BITS'(1);
								end
							end
							default: begin
							end
						endcase
						n.state = ack ? ST_RX_ACK : ST_IDLE;
						n.sdaOe_n = !ack;
					end
				end
				ST_RX_ACK: begin
					if (sclFall) begin
						n.bitCnt = 4'h0;
						if (r.readMode) begin
							n.state = ST_TX;
							n.shift = txByte;
							n.sdaOe_n = txByte[7];
						end else begin
							n.sdaOe_n = 1'b1;
							n.state = (r.kind == K_SLAVE || r.resArmed) ? ST_IDLE : ST_RX;
						end
					end
				end
				ST_TX: begin
					if (sclRise) begin
						n.bitCnt = r.bitCnt + 4'h1;
					end else if (sclFall && r.bitCnt == ACK_SLOT) begin
						n.state = ST_TX_ACK;
						n.sdaOe_n = 1'b1;
						if (r.idMode) begin
							n.idIdx = (r.idIdx == 2'(ID_BYTES - 1)) ? 2'h0 : r.idIdx + 2'h1;
						end else begin
							n.addr = r.addr + ADDR_BITS'(1);
						end
					end else if (sclFall) begin
						n.shift = {r.shift[6:0], 1'b0};
						n.sdaOe_n = r.shift[6];
					end
				end
				ST_TX_ACK: begin
					if (sclRise) begin
						if (sdaNew) begin
							n.state = ST_IDLE;
							n.idMode = 1'b0;
						end else begin
							n.bitCnt = ACKED_SLOT;
						end
					end else if (sclFall && r.bitCnt == ACKED_SLOT) begin
						n.state = ST_TX;
						n.bitCnt = 4'h0;
						n.shift = txByte;
						n.sdaOe_n = txByte[7];
					end
				end
				default: begin
					n.state = ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{sclSync: 3'h7, sdaSync: 3'h7, wpSync: 3'h0, scl: 1'b1, sda: 1'b1,
				state: ST_IDLE, kind: K_SLAVE, sdaOe_n: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	// Array write on the eighth bit, on the same clock edge that starts driving the ack.
	always_ff @(posedge core_clk) begin
		if (memWe) begin
			mem[r.addr] <= r.shift;
		end
	end

	// ==========================================================
	// Outputs.
	assign link.dSdaOut = 1'b0;
	assign link.dSdaOe_n = r.sdaOe_n;
	assign asleep = r.asleep;
endmodule : nvram_i2c_device

/* src/nvram_i2c_master.sv */
// Byte-level two-wire bus master driven from a small register port.
`timescale 1ns/1ps
module nvram_i2c_master import nvram_i2c_pkg::*; #(
	parameter int QUARTER_CYCLES = SCL_QUARTER_CYCLES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port.
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Two-wire link.
	i2c_link_if.master link
);
	// ==========================================================
	// Types and state.
	localparam int DIV_W = $clog2(QUARTER_CYCLES + 1);
	typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BIT} mst_state_type;
	typedef struct packed {
		logic [2:0] sdaSync;
		logic sda;
		mst_state_type state;
		logic isWrite;
		logic [DIV_W-1:0] divCnt;
		logic [1:0] phase;
		logic [3:0] bitIdx;
		logic [7:0] txData;
		logic [7:0] txShift;
		logic [7:0] rxShift;
		logic ackSend;
		logic nackRx;
		logic sclOe_n;
		logic sdaOe_n;
		logic [7:0] rdata;
	} mst_reg_type;
	mst_reg_type r;
	mst_reg_type n;
	logic tick;
	logic busy;

	// ==========================================================
	// Quarter-bit divider, register port and line sequencer.
	always_comb begin
		n = r;
		busy = (r.state != M_IDLE);
		tick = (r.divCnt == DIV_W'(QUARTER_CYCLES - 1));
		n.sdaSync = {r.sdaSync[1:0], link.sdaLevel};
		if (r.sdaSync[1] == r.sdaSync[2]) begin
			n.sda = r.sdaSync[1];
		end
		n.divCnt = tick ? '0 : r.divCnt + DIV_W'(1);
		// Register reads answer one cycle later; unmapped reads give zero.
		n.rdata = 8'h00;
		if (regRd) begin
			unique case (regAddr)
				REG_CMD: n.rdata = {7'h00, busy};
				REG_DATA: n.rdata = r.rxShift;
				REG_STATUS: n.rdata = {6'h00, r.nackRx, busy};
				default: n.rdata = 8'h00;
			endcase
		end
		if (regWr && regAddr == REG_DATA) begin
			n.txData = regWdata;
		end
		// Commands while busy are ignored.
		if (regWr && regAddr == REG_CMD && !busy) begin
			n.divCnt = '0;
			n.phase = 2'h0;
			n.bitIdx = 4'h0;
			n.ackSend = regWdata[CMD_ACK_BIT];
			n.isWrite = (regWdata[1:0] == OP_WRITE);
			n.txShift = r.txData;
			unique case (regWdata[1:0])
				OP_START: n.state = M_START;
				OP_STOP: n.state = M_STOP;
				default: n.state = M_BIT;
			endcase
		end else if (busy && tick) begin
			n.phase = r.phase + 2'h1;
			unique case (r.state)
				M_START: begin
					unique case (r.phase)
						2'h0: n.sdaOe_n = 1'b1;
						2'h1: n.sclOe_n = 1'b1;
						2'h2: n.sdaOe_n = 1'b0;
						default: begin
							n.sclOe_n = 1'b0;
							n.state = M_IDLE;
						end
					endcase
				end
				M_STOP: begin
					unique case (r.phase)
						2'h0: n.sdaOe_n = 1'b0;
						2'h1: n.sclOe_n = 1'b1;
						2'h2: n.sdaOe_n = 1'b1;
						default: n.state = M_IDLE;
					endcase
				end
				M_BIT: begin
					unique case (r.phase)
						2'h0: begin
							if (r.bitIdx < ACK_SLOT) begin
								n.sdaOe_n = r.isWrite ? r.txShift[7] : 1'b1;
							end else begin
								n.sdaOe_n = r.isWrite ? 1'b1 : !r.ackSend;
							end
						end
						2'h1: n.sclOe_n = 1'b1;
						2'h2: begin
							if (r.bitIdx < ACK_SLOT) begin
								n.rxShift = {r.rxShift[6:0], r.sda};
							end else if (r.isWrite) begin
								n.nackRx = r.sda;
							end
						end
						default: begin
							n.sclOe_n = 1'b0;
							n.txShift = {r.txShift[6:0], 1'b0};
							n.bitIdx = r.bitIdx + 4'h1;
							if (r.bitIdx == ACK_SLOT) begin
								n.state = M_IDLE;
							end
						end
					endcase
				end
				default: n.state = M_IDLE;
			endcase
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{sdaSync: 3'h7, sda: 1'b1, state: M_IDLE, sclOe_n: 1'b1, sdaOe_n: 1'b1,
				default: '0};
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs.
	assign regRdata = r.rdata;
	assign link.mSclOut = 1'b0;
	assign link.mSdaOut = 1'b0;
	assign link.mSclOe_n = r.sclOe_n;
	assign link.mSdaOe_n = r.sdaOe_n;
endmodule : nvram_i2c_master

/* dv/nvram_i2c_link_asserts.sv */
// Concurrent checks on the two-wire link between the master and the memory slave.
`timescale 1ns/1ps
module nvram_i2c_link_asserts (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Link signals.
	input wire logic mSclOut,
	input wire logic mSclOe_n,
	input wire logic mSdaOut,
	input wire logic mSdaOe_n,
	input wire logic dSdaOut,
	input wire logic dSdaOe_n,
	input wire logic sclLevel,
	input wire logic sdaLevel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// Helper logic.
	logic [9:0] lowCnt_r;
	logic [9:0] lowCnt_nxt;
	// Counts how long the slave keeps the data line pulled low.
	always_comb begin
		lowCnt_nxt = dSdaOe_n ? 10'h000 : lowCnt_r + 10'h001;
	end
	// Registers the count.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lowCnt_r <= 10'h000;
		end else begin
			lowCnt_r <= lowCnt_nxt;
		end
	end
	// ==========================================================
	// Assertions.
	a_drive_scl_low: assert property ($fell(dSdaOe_n) |-> !sclLevel)
		else $error("slave started driving while the clock was high");
	a_stable_scl_high: assert property (sclLevel && $past(sclLevel) && mSdaOe_n && $past(mSdaOe_n)
		|-> $stable(dSdaOe_n))
		else $error("slave data changed while the clock was high");
	a_ack_hold: assert property ($fell(dSdaOe_n) |-> ##1 !dSdaOe_n [*8])
		else $error("slave released a bit too early");
	a_drive_bounded: assert property (lowCnt_r < 10'h258)
		else $error("slave kept the data line too long");
	a_release_stop: assert property (sclLevel && $rose(sdaLevel) |-> dSdaOe_n [*8])
		else $error("slave drove the line after a stop");
	a_quiet_start: assert property (sclLevel && $fell(sdaLevel) |-> ##1 dSdaOe_n [*8])
		else $error("slave drove the line right after a start");
	a_scl_high_width: assert property ($rose(sclLevel) |-> sclLevel [*8])
		else $error("clock high phase too short");
	a_scl_low_width: assert property ($fell(sclLevel) |-> !sclLevel [*8])
		else $error("clock low phase too short");
endmodule : nvram_i2c_link_asserts

/* dv/serial_nvram_slave_ops_bench.sv */
// Self-checking bench: register-port master facing the memory slave.
`timescale 1ns/1ps
module serial_nvram_slave_ops_bench import nvram_i2c_pkg::*;;
	// ==========================================================
	// Constants and signals.
	localparam logic [2:0] SEL = 3'h5;
	localparam logic [7:0] ADW = {TYPE_CODE, SEL, 1'b0};
	localparam logic [7:0] ADR = {TYPE_CODE, SEL, 1'b1};
	localparam logic [11:0] MFR = 12'h5a3; // Arbitrary value.
	localparam logic [3:0] DEN = 4'h6; // Arbitrary value.
	localparam logic [4:0] VARI = 5'h1f; // Arbitrary value.
	localparam logic [2:0] REV = 3'h5; // Arbitrary value.
	localparam logic [23:0] ID_WORD = {MFR, DEN, VARI & 5'h0e, REV};
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic writeProtect = 1'b0;
	logic asleep;
	logic [7:0] st;
	logic [7:0] rv;
	int errors = 0;
	int cmp_count = 0;
	// Free-running core clock.
	always #2 core_clk = ~core_clk;
	// ==========================================================
	// Design and checker.
	i2c_link_if link();
	nvram_i2c_master #(.QUARTER_CYCLES(8)) i_nvram_i2c_master (.core_clk(core_clk),
		.arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .link(link));
	nvram_i2c_device #(.WAKE_CYCLES(600), .MFR_ID(MFR), .DENSITY_ID(DEN), .VARIATION_ID(VARI),
		.DIE_REV(REV)) i_nvram_i2c_device (.core_clk(core_clk), .arst_n(arst_n),
		.link(link), .addrSel(SEL), .writeProtect(writeProtect), .asleep(asleep));
	nvram_i2c_link_asserts i_nvram_i2c_link_asserts (.core_clk(core_clk), .arst_n(arst_n),
		.mSclOut(link.mSclOut), .mSclOe_n(link.mSclOe_n), .mSdaOut(link.mSdaOut),
		.mSdaOe_n(link.mSdaOe_n), .dSdaOut(link.dSdaOut), .dSdaOe_n(link.dSdaOe_n),
		.sclLevel(link.sclLevel), .sdaLevel(link.sdaLevel));
	// ==========================================================
	// Tasks.
	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	// Issues one bus operation and polls until the master is idle again.
	task op(input logic [1:0] code, input logic ackSend);
		int n;
		n = 0;
		st = 8'h01;
		wr(REG_CMD, {5'h00, ackSend, code});
		while (st[STAT_BUSY_BIT] !== 1'b0 && n < 3000) begin
			rd(REG_STATUS, st);
			n++;
		end
		if (st[STAT_BUSY_BIT] !== 1'b0) begin
			errors++;
			$display("unexpected at %0t: master stuck busy", $time);
			test_done();
		end
	endtask : op
	task sendb(input logic [7:0] d, input logic nk);
		wr(REG_DATA, d);
		op(OP_WRITE, 1'b0);
		chk({7'h00, st[STAT_NACK_BIT]}, {7'h00, nk});
	endtask : sendb
	task getb(input logic ackSend, input logic [7:0] exp);
		op(OP_READ, ackSend);
		rd(REG_DATA, rv);
		chk(rv, exp);
	endtask : getb
	// ==========================================================
	// Main sequence.
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		// Write across the top of the array, then read it back selectively.
		op(OP_START, 1'b0);
		sendb(ADW, 1'b0); // Write address.
		sendb(8'hbf, 1'b0); // Top bits ignored.
		sendb(8'hff, 1'b0);
		sendb(8'h11, 1'b0); // Data accepted.
		sendb(8'h22, 1'b0); // After wrap.
		sendb(8'h33, 1'b0); // No page buffer.
		op(OP_START, 1'b0);
		sendb(ADW, 1'b0); // Ready at once.
		sendb(8'h3f, 1'b0);
		sendb(8'hff, 1'b0);
		op(OP_START, 1'b0);
		sendb(ADR, 1'b0); // Selective read.
		getb(1'b1, 8'h11); // First byte.
		getb(1'b1, 8'h22); // Wrapped byte.
		getb(1'b0, 8'h33); // Last byte.
		op(OP_STOP, 1'b0);
		$display("test 1 done");
		// Protected write leaves data and counter alone.
		op(OP_START, 1'b0);
		sendb(ADW, 1'b0);
		sendb(8'h00, 1'b0);
		sendb(8'h05, 1'b0);
		sendb(8'h3c, 1'b0); // Unprotected.
		op(OP_STOP, 1'b0);
		@(posedge core_clk);
		writeProtect <= 1'b1;
		op(OP_START, 1'b0);
		sendb(ADW, 1'b0);
		sendb(8'h00, 1'b0);
		sendb(8'h05, 1'b0);
		sendb(8'h5a, 1'b1); // Refused.
		op(OP_STOP, 1'b0);
		@(posedge core_clk);
		writeProtect <= 1'b0;
		op(OP_START, 1'b0);
		sendb(ADR, 1'b0);
		getb(1'b0, 8'h3c); // Counter held.
		op(OP_STOP, 1'b0);
		$display("test 2 done");
		// Identity word, then a foreign address after the prefix.
		op(OP_START, 1'b0);
		sendb(RES_ID_PREFIX, 1'b0); // Prefix.
		sendb(ADR, 1'b0); // Direction ignored.
		op(OP_START, 1'b0);
		sendb(RES_ID_IDENT, 1'b0); // Identity code.
		getb(1'b1, ID_WORD[23:16]); // Maker.
		getb(1'b1, ID_WORD[15:8]); // Density.
		getb(1'b0, ID_WORD[7:0]); // Fixed bits.
		op(OP_STOP, 1'b0);
		op(OP_START, 1'b0);
		sendb(RES_ID_PREFIX, 1'b0);
		sendb({TYPE_CODE, 3'h2, 1'b0}, 1'b1); // Other device.
		op(OP_START, 1'b0);
		sendb({TYPE_CODE, 3'h2, 1'b1}, 1'b1); // Other select pins.
		op(OP_STOP, 1'b0);
		$display("test 3 done");
		// Sleep, then wake by polling for acknowledge.
		op(OP_START, 1'b0);
		sendb(RES_ID_PREFIX, 1'b0);
		sendb(ADW, 1'b0);
		op(OP_START, 1'b0);
		sendb(RES_ID_SLEEP, 1'b0); // Sleep code.
		chk({7'h00, asleep}, 8'h00); // Not before the stop.
		op(OP_STOP, 1'b0);
		chk({7'h00, asleep}, 8'h01); // Asleep.
		op(OP_START, 1'b0);
		sendb(ADW, 1'b1); // Wake refused.
		op(OP_STOP, 1'b0);
		op(OP_START, 1'b0);
		sendb(ADW, 1'b1); // Still waking.
		for (int i = 0; i < 4 && st[STAT_NACK_BIT] !== 1'b0; i++) begin
			op(OP_START, 1'b0);
			wr(REG_DATA, ADW);
			op(OP_WRITE, 1'b0);
		end
		chk({7'h00, st[STAT_NACK_BIT]}, 8'h00); // Awake.
		op(OP_STOP, 1'b0);
		chk({7'h00, asleep}, 8'h00); // Normal.
		$display("test 4 done");
		test_done();
	end
endmodule : serial_nvram_slave_ops_bench
